// File: core/flow_pkg.sv
// flow control package: pipeline timing constants, return stack layout, carriers
// assumes one core clock domain; no software-visible registers
package flow_pkg;
    localparam int          RAS_DEPTH          = 4;
    localparam int          RAS_PTR_W          = 2;
    localparam int          RAS_CNT_W          = 3;
    localparam logic [31:0] RAS_RESET_ADDR     = 32'h0000_0000;
    localparam logic [2:0]  COST_ZERO          = 3'h0;
    localparam logic [2:0]  COST_ONE           = 3'h1;
    localparam logic [2:0]  COST_TWO           = 3'h2;
    localparam logic [2:0]  COST_MISS          = 3'h4;
    localparam logic [2:0]  COST_MULTI_MISS    = 3'h6;
    localparam logic [3:0]  LAT_W_RESET        = 4'h0;
    localparam int          NUM_REGS           = 16;

    typedef enum logic [1:0] {
        PIPE_MUL  = 2'h0,
        PIPE_ALU  = 2'h1,
        PIPE_DATA = 2'h2,
        PIPE_NONE = 2'h3
    } subpipe_e;

    typedef enum logic [2:0] {
        FLOW_DISP_BRANCH = 3'h0,
        FLOW_REL_JUMP    = 3'h1,
        FLOW_REL_CALL    = 3'h2,
        FLOW_RET_COND    = 3'h3,
        FLOW_RET_ALWAYS  = 3'h4,
        FLOW_MOV_LINK    = 3'h5,
        FLOW_MULTI_POP   = 3'h6,
        FLOW_MULTI_LOAD  = 3'h7
    } flow_kind_e;

    typedef struct packed {
        logic       valid;
        subpipe_e   pipe;
        logic [3:0] dst;
        logic       dst_wide;
        logic [3:0] dst_hi;
        logic [3:0] src_a;
        logic [3:0] src_b;
        logic       uses_flags;
        logic       sets_flags;
        logic [3:0] issue_lat;
        logic [3:0] result_lat;
        logic [3:0] result_lat_hi;
        logic [3:0] flag_lat;
    } issue_req_s;

    typedef struct packed {
        logic       valid;
        flow_kind_e kind;
        logic       predicted;
        logic       folded;
        logic       mispredicted;
        logic [31:0] ret_addr;
        logic [31:0] target;
    } flow_req_s;
endpackage : flow_pkg

// File: core/ret_addr_stack.sv
// four-entry circular return address stack with hardware-kept valid count
// assumes push and pop requests are single-cycle pulses from the flow logic
`timescale 1ns/1ps
module ret_addr_stack
    import flow_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        push,
    input  wire logic [31:0] push_addr,
    input  wire logic        pop,
    output logic             hit,
    output logic [31:0]      top_addr,
    output logic [RAS_CNT_W-1:0] count
);
    logic [31:0]          entry_ff [RAS_DEPTH];
    logic [RAS_PTR_W-1:0] top_ff;
    logic [RAS_CNT_W-1:0] cnt_ff;
    logic [RAS_PTR_W-1:0] nxt_top;

    assign hit      = (cnt_ff != '0);
    assign top_addr = entry_ff[top_ff - RAS_PTR_W'(1)];
    assign count    = cnt_ff;
    assign nxt_top  = top_ff + RAS_PTR_W'(1);

    // circular write overwrites oldest when full
    always_ff @(posedge clk) begin
        if (push) begin
            entry_ff[top_ff] <= push_addr;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            top_ff <= '0;
        end else if (push) begin
            top_ff <= nxt_top;
        end else if (pop && hit) begin
            top_ff <= top_ff - RAS_PTR_W'(1);
        end
    end

    // saturating count, no fault on over or underflow
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_ff <= '0;
        end else if (push) begin
            if (cnt_ff != RAS_CNT_W'(RAS_DEPTH)) begin
                cnt_ff <= cnt_ff + RAS_CNT_W'(1);
            end
        end else if (pop && hit) begin
            cnt_ff <= cnt_ff - RAS_CNT_W'(1);
        end
    end
endmodule : ret_addr_stack

// File: core/flow_ctrl.sv
// pipeline flow control: issue interlock, forwarding timing, flow cost and redirects
// assumes issue stage holds a request until ISSUE_READY; one core clock
`timescale 1ns/1ps
// Behaviour
// - instruction issues when it leaves issue stage into a subpipe
// - next instruction to another subpipe without hazard issues after one cycle
// - after result latency the value forwards and dependents proceed
// - wide results make low and high parts ready at separate latencies
// - flags forward so a branch after a flag setter with flag latency one does not stall
// - most instructions may write the program counter as a jump
// - program counter writes redirect only from writeback, without forwarding
// - mispredicted branch costs four cycles, correct prediction one cycle
// - folded branch costs zero cycles if correct, four if wrong
// - return address stack holds four entries
// - push onto a full stack overwrites the oldest entry
// - hardware tracks the count of valid stack entries
// - stack over and underflow only cost performance, no fault
// - return with empty stack is treated as unpredicted
// - multi pop or load with pc costs two predicted, six unpredicted
module flow_ctrl
    import flow_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire issue_req_s  ISSUE_REQ,
    output logic             ISSUE_READY,
    output logic             ISSUE_FIRE,
    output logic [1:0]       ISSUE_PIPE,
    input  wire flow_req_s   FLOW_REQ,
    output logic             FLOW_BUSY,
    output logic [2:0]       FLOW_COST,
    output logic             RET_PREDICTED,
    output logic [31:0]      RET_TARGET,
    input  wire logic        WB_PC_WRITE,
    input  wire logic [31:0] WB_PC_VALUE,
    output logic             REDIRECT,
    output logic [31:0]      REDIRECT_ADDR,
    output logic [RAS_CNT_W-1:0] RAS_COUNT
);
    typedef enum logic [1:0] {
        ST_RUN   = 2'b01,
        ST_STALL = 2'b10
    } flow_state_e;

    logic [3:0]  ready_lo_ff [NUM_REGS];
    logic [3:0]  pipe_busy_ff [3];
    logic [3:0]  flag_wait_ff;
    logic        hazard;
    logic        pipe_free;
    logic        fire;
    flow_state_e state_ff;
    logic [2:0]  stall_ff;
    logic [2:0]  cost;
    logic        ras_push;
    logic        ras_pop;
    logic        ras_hit;
    logic [31:0] ras_top;
    logic        is_ret;
    logic        flow_go;
    logic [2:0]  cost_ff;
    logic        ret_pred_ff;
    logic [31:0] ret_tgt_ff;
    logic        redirect_ff;
    logic [31:0] redirect_addr_ff;

    // operand readiness from forwarding countdowns
    always_comb begin
        hazard = 1'b0;
        if (ISSUE_REQ.valid) begin
            if (ready_lo_ff[ISSUE_REQ.src_a] != LAT_W_RESET) begin
                hazard = 1'b1;
            end
            if (ready_lo_ff[ISSUE_REQ.src_b] != LAT_W_RESET) begin
                hazard = 1'b1;
            end
            if (ISSUE_REQ.uses_flags && flag_wait_ff != LAT_W_RESET) begin
                hazard = 1'b1;
            end
        end
    end

    assign pipe_free   = (ISSUE_REQ.pipe == PIPE_NONE) ||
                         (pipe_busy_ff[ISSUE_REQ.pipe] == LAT_W_RESET);
    assign ISSUE_READY = !hazard && pipe_free && state_ff == ST_RUN;
    assign fire        = ISSUE_REQ.valid && ISSUE_READY;
    assign ISSUE_FIRE  = fire;
    assign ISSUE_PIPE  = ISSUE_REQ.pipe;

    // per-register result countdown, wide results split
    always_ff @(posedge CLK) begin
        if (RST) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                ready_lo_ff[i] <= LAT_W_RESET;
            end
        end else begin
            for (int i = 0; i < NUM_REGS; i++) begin
                if (fire && ISSUE_REQ.dst == 4'(i) && ISSUE_REQ.result_lat > 4'h1) begin
                    ready_lo_ff[i] <= ISSUE_REQ.result_lat - 4'h1;
                end else if (fire && ISSUE_REQ.dst_wide && ISSUE_REQ.dst_hi == 4'(i)
                             && ISSUE_REQ.result_lat_hi > 4'h1) begin
                    ready_lo_ff[i] <= ISSUE_REQ.result_lat_hi - 4'h1;
                end else if (ready_lo_ff[i] != LAT_W_RESET) begin
                    ready_lo_ff[i] <= ready_lo_ff[i] - 4'h1;
                end
            end
        end
    end

    // same-subpipe issue spacing
    always_ff @(posedge CLK) begin
        if (RST) begin
            for (int p = 0; p < 3; p++) begin
                pipe_busy_ff[p] <= LAT_W_RESET;
            end
        end else begin
            for (int p = 0; p < 3; p++) begin
                if (fire && ISSUE_REQ.pipe == subpipe_e'(p) && ISSUE_REQ.issue_lat > 4'h1) begin
                    pipe_busy_ff[p] <= ISSUE_REQ.issue_lat - 4'h1;
                end else if (pipe_busy_ff[p] != LAT_W_RESET) begin
                    pipe_busy_ff[p] <= pipe_busy_ff[p] - 4'h1;
                end
            end
        end
    end

    // flag countdown; latency one means forwarded, no stall
    always_ff @(posedge CLK) begin
        if (RST) begin
            flag_wait_ff <= LAT_W_RESET;
        end else if (fire && ISSUE_REQ.sets_flags && ISSUE_REQ.flag_lat > 4'h1) begin
            flag_wait_ff <= ISSUE_REQ.flag_lat - 4'h1;
        end else if (flag_wait_ff != LAT_W_RESET) begin
            flag_wait_ff <= flag_wait_ff - 4'h1;
        end
    end

    // change-of-flow cost table
    assign is_ret = FLOW_REQ.kind == FLOW_RET_COND || FLOW_REQ.kind == FLOW_RET_ALWAYS
                 || FLOW_REQ.kind == FLOW_MOV_LINK || FLOW_REQ.kind == FLOW_MULTI_POP
                 || FLOW_REQ.kind == FLOW_MULTI_LOAD;

    always_comb begin
        cost = COST_MISS;
        case (FLOW_REQ.kind)
            FLOW_DISP_BRANCH, FLOW_REL_JUMP: begin
                if (!FLOW_REQ.predicted || FLOW_REQ.mispredicted) begin
                    cost = COST_MISS;
                end else if (FLOW_REQ.folded) begin
                    cost = COST_ZERO;
                end else begin
                    cost = COST_ONE;
                end
            end
            FLOW_REL_CALL: begin
                if (FLOW_REQ.predicted && !FLOW_REQ.mispredicted) begin
                    cost = COST_ONE;
                end else begin
                    cost = COST_MISS;
                end
            end
            FLOW_RET_COND: begin
                if (ras_hit && FLOW_REQ.predicted && !FLOW_REQ.mispredicted) begin
                    cost = COST_ONE;
                end else begin
                    cost = COST_MISS;
                end
            end
            FLOW_RET_ALWAYS, FLOW_MOV_LINK: begin
                cost = ras_hit ? COST_TWO : COST_MISS;
            end
            FLOW_MULTI_POP, FLOW_MULTI_LOAD: begin
                cost = ras_hit ? COST_TWO : COST_MULTI_MISS;
            end
            default: begin
                cost = COST_MISS;
            end
        endcase
    end

    assign flow_go  = FLOW_REQ.valid && state_ff == ST_RUN;
    assign ras_push = flow_go && FLOW_REQ.kind == FLOW_REL_CALL;
    assign ras_pop  = flow_go && is_ret;

    // busy for cycles beyond the first
    always_ff @(posedge CLK) begin
        if (RST) begin
            state_ff <= ST_RUN;
            stall_ff <= COST_ZERO;
        end else begin
            case (state_ff)
                ST_RUN: begin
                    if (flow_go && cost > COST_ONE) begin
                        state_ff <= ST_STALL;
                        stall_ff <= cost - COST_ONE;
                    end
                end
                ST_STALL: begin
                    if (stall_ff == COST_ONE) begin
                        state_ff <= ST_RUN;
                    end
                    stall_ff <= stall_ff - COST_ONE;
                end
                default: begin
                    state_ff <= ST_RUN;
                    stall_ff <= COST_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            cost_ff     <= COST_ZERO;
            ret_pred_ff <= 1'b0;
            ret_tgt_ff  <= RAS_RESET_ADDR;
        end else if (flow_go) begin
            cost_ff     <= cost;
            ret_pred_ff <= is_ret && ras_hit;
            ret_tgt_ff  <= ras_top;
        end
    end

    // pc-destination jump taken from writeback only
    always_ff @(posedge CLK) begin
        if (RST) begin
            redirect_ff      <= 1'b0;
            redirect_addr_ff <= RAS_RESET_ADDR;
        end else begin
            redirect_ff <= WB_PC_WRITE;
            if (WB_PC_WRITE) begin
                redirect_addr_ff <= WB_PC_VALUE;
            end
        end
    end

    assign FLOW_BUSY     = state_ff == ST_STALL;
    assign FLOW_COST     = cost_ff;
    assign RET_PREDICTED = ret_pred_ff;
    assign RET_TARGET    = ret_tgt_ff;
    assign REDIRECT      = redirect_ff;
    assign REDIRECT_ADDR = redirect_addr_ff;

    ret_addr_stack u_ras (
        .clk       (CLK),
        .rst       (RST),
        .push      (ras_push),
        .push_addr (FLOW_REQ.ret_addr),
        .pop       (ras_pop),
        .hit       (ras_hit),
        .top_addr  (ras_top),
        .count     (RAS_COUNT)
    );
endmodule : flow_ctrl

// File: dv/wb_stage_model.sv
// writeback side model: hands back a pc write some cycles after a jump request
// assumes the bench pulses go for one cycle with the value and delay
`timescale 1ns/1ps
module wb_stage_model
    import flow_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        go,
    input  wire logic [31:0] val,
    input  wire logic [3:0]  dly,
    output logic             pc_wr,
    output logic [31:0]      pc_val
);
    logic [3:0]  cnt_ff;
    logic [31:0] val_ff;
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_ff <= 4'h0;
            val_ff <= 32'h0;
        end else if (go) begin
            cnt_ff <= dly;
            val_ff <= val;
        end else if (cnt_ff != 4'h0) begin
            cnt_ff <= cnt_ff - 4'h1;
        end
    end
    // pc destination reaches writeback after the delay
    assign pc_wr  = (cnt_ff == 4'h1);
    // value not held once the write is gone
    assign pc_val = pc_wr ? val_ff : ~val_ff;
endmodule : wb_stage_model

// File: dv/flow_ctrl_props.sv
// checker for flow_ctrl: issue, flow cost, stack count and redirect timing
// assumes it is bound to the flow_ctrl ports, one clock
`timescale 1ns/1ps
module flow_ctrl_props
    import flow_pkg::*;
(
    input wire logic        CLK,
    input wire logic        RST,
    input wire issue_req_s  ISSUE_REQ,
    input wire logic        ISSUE_READY,
    input wire logic        ISSUE_FIRE,
    input wire flow_req_s   FLOW_REQ,
    input wire logic        FLOW_BUSY,
    input wire logic [2:0]  FLOW_COST,
    input wire logic        WB_PC_WRITE,
    input wire logic [31:0] WB_PC_VALUE,
    input wire logic        REDIRECT,
    input wire logic [31:0] REDIRECT_ADDR,
    input wire logic [RAS_CNT_W-1:0] RAS_COUNT
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    logic take;
    assign take = FLOW_REQ.valid && !FLOW_BUSY;
    a_pipe_spacing: assert property (
        ISSUE_FIRE && ISSUE_REQ.pipe != PIPE_NONE && ISSUE_REQ.issue_lat > 4'h1
        |=> ISSUE_REQ.pipe != $past(ISSUE_REQ.pipe) || !ISSUE_READY)
        else $error("same subpipe issued too early");
    a_busy_blocks_issue: assert property (
        FLOW_BUSY |-> !ISSUE_READY && !ISSUE_FIRE)
        else $error("issue during flow stall");
    a_redirect_from_wb: assert property (
        WB_PC_WRITE |=> REDIRECT && REDIRECT_ADDR == $past(WB_PC_VALUE))
        else $error("redirect missing or wrong");
    a_redirect_cause: assert property (REDIRECT |-> $past(WB_PC_WRITE))
        else $error("redirect without writeback");
    a_stack_bound: assert property (RAS_COUNT <= 3'h4)
        else $error("stack count above four");
    a_push_count: assert property (take && FLOW_REQ.kind == FLOW_REL_CALL |=>
        RAS_COUNT == (($past(RAS_COUNT) == 3'h4) ? 3'h4 : $past(RAS_COUNT) + 3'h1))
        else $error("push count wrong");
    a_fold_free: assert property (
        take && FLOW_REQ.kind inside {FLOW_DISP_BRANCH, FLOW_REL_JUMP}
        && FLOW_REQ.predicted && FLOW_REQ.folded && !FLOW_REQ.mispredicted
        |=> FLOW_COST == COST_ZERO && !FLOW_BUSY)
        else $error("folded branch not free");
    a_miss_stall: assert property (
        take && FLOW_REQ.kind inside {FLOW_DISP_BRANCH, FLOW_REL_JUMP, FLOW_REL_CALL}
        && (!FLOW_REQ.predicted || FLOW_REQ.mispredicted)
        |=> (FLOW_COST == COST_MISS && FLOW_BUSY) [*3] ##1 !FLOW_BUSY)
        else $error("miss stall length wrong");
    a_multi_empty: assert property (
        take && FLOW_REQ.kind inside {FLOW_MULTI_POP, FLOW_MULTI_LOAD} && RAS_COUNT == 3'h0
        |=> (FLOW_COST == COST_MULTI_MISS && FLOW_BUSY) [*5] ##1 !FLOW_BUSY)
        else $error("unpredicted multi pop cost wrong");
endmodule : flow_ctrl_props
bind flow_ctrl flow_ctrl_props u_props (.CLK, .RST, .ISSUE_REQ, .ISSUE_READY, .ISSUE_FIRE,
    .FLOW_REQ, .FLOW_BUSY, .FLOW_COST, .WB_PC_WRITE, .WB_PC_VALUE, .REDIRECT, .REDIRECT_ADDR,
    .RAS_COUNT);

// File: dv/branch_predict_return_stack_timing_tb.sv
// bench for flow_ctrl: issue waits, flow costs, return stack and redirect
// assumes flow_pkg, flow_ctrl, wb_stage_model and the checker are compiled first
`timescale 1ns/1ps
module branch_predict_return_stack_timing_tb
    import flow_pkg::*;
;
    typedef struct {flow_kind_e k; logic [2:0] b; logic [2:0] c; logic [2:0] n;} row_s;
    logic        clk = 1'h0;
    logic        rst = 1'h1;
    issue_req_s  issue_req = '0;
    flow_req_s   flow_req = '0;
    logic        go = 1'h0;
    logic [31:0] go_val = 32'h0;
    logic [3:0]  go_dly = 4'h0;
    logic        issue_ready, issue_fire, flow_busy, ret_pred, wb_wr, redirect;
    logic [1:0]  issue_pipe;
    logic [2:0]  flow_cost;
    logic [31:0] ret_target, wb_val, redir_addr;
    logic [RAS_CNT_W-1:0] ras_count;
    int          errors = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    // kind, {predicted, folded, mispredicted}, cost, stack count
    row_s rows[20] = '{'{FLOW_DISP_BRANCH, 3'h6, 3'h0, 3'h0}, '{FLOW_DISP_BRANCH, 3'h4, 3'h1, 3'h0},
        '{FLOW_DISP_BRANCH, 3'h5, 3'h4, 3'h0}, '{FLOW_REL_JUMP, 3'h7, 3'h4, 3'h0},
        '{FLOW_REL_JUMP, 3'h0, 3'h4, 3'h0}, '{FLOW_REL_CALL, 3'h6, 3'h1, 3'h1},
        '{FLOW_REL_CALL, 3'h7, 3'h4, 3'h2}, '{FLOW_RET_ALWAYS, 3'h4, 3'h2, 3'h1},
        '{FLOW_MOV_LINK, 3'h4, 3'h2, 3'h0}, '{FLOW_RET_ALWAYS, 3'h4, 3'h4, 3'h0},
        '{FLOW_RET_COND, 3'h4, 3'h4, 3'h0}, '{FLOW_MULTI_POP, 3'h4, 3'h6, 3'h0},
        '{FLOW_MULTI_LOAD, 3'h4, 3'h6, 3'h0}, '{FLOW_REL_CALL, 3'h4, 3'h1, 3'h1},
        '{FLOW_RET_COND, 3'h4, 3'h1, 3'h0}, '{FLOW_REL_CALL, 3'h4, 3'h1, 3'h1},
        '{FLOW_MULTI_LOAD, 3'h4, 3'h2, 3'h0}, '{FLOW_REL_CALL, 3'h4, 3'h1, 3'h1},
        '{FLOW_MULTI_POP, 3'h4, 3'h2, 3'h0}, '{FLOW_REL_CALL, 3'h4, 3'h1, 3'h1}};

    flow_ctrl DUT (.CLK(clk), .RST(rst), .ISSUE_REQ(issue_req), .ISSUE_READY(issue_ready),
        .ISSUE_FIRE(issue_fire), .ISSUE_PIPE(issue_pipe), .FLOW_REQ(flow_req), .FLOW_BUSY(flow_busy),
        .FLOW_COST(flow_cost), .RET_PREDICTED(ret_pred), .RET_TARGET(ret_target),
        .WB_PC_WRITE(wb_wr), .WB_PC_VALUE(wb_val), .REDIRECT(redirect), .REDIRECT_ADDR(redir_addr),
        .RAS_COUNT(ras_count));
    wb_stage_model u_wb (.clk(clk), .rst(rst), .go(go), .val(go_val), .dly(go_dly), .pc_wr(wb_wr),
        .pc_val(wb_val));

    always #12.5 clk = ~clk;

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic close_out();
        if (errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    function automatic issue_req_s ir(input subpipe_e p, input logic [3:0] d, h, s, il, rl, rh, fl,
                                      input logic fu);
        return '{1'h1, p, d, h != 4'h0, h, s, s, fu, fl != 4'h0, il, rl, rh, fl};
    endfunction : ir

    // fire a, then count cycles until b may issue
    task automatic iss(input issue_req_s a, input issue_req_s b, input int w);
        int k;
        k = 0;
        @(posedge clk);
        #1 issue_req = a;
        @(posedge clk);
        #1 issue_req = b;
        #1 while (issue_ready !== 1'h1 && k < 10) begin
            @(posedge clk);
            #2 k++;
        end
        chk({issue_fire, issue_pipe}, {1'h1, b.pipe});
        chk(k, w);
        @(posedge clk);
        #1 issue_req = '0;
    endtask : iss

    // one flow op: cost, stack count, then stall length
    task automatic fl(input flow_kind_e k, input logic [2:0] b, input logic [31:0] ra,
                      input logic [2:0] c, input logic [2:0] n);
        int w;
        w = 0;
        @(posedge clk);
        #1 flow_req = '{1'h1, k, b[2], b[1], b[0], ra, 32'h0};
        @(posedge clk);
        #1 flow_req.valid = 1'h0;
        #1 chk({flow_cost, ras_count}, {c, n});
        while (flow_busy === 1'h1 && w < 10) begin
            @(posedge clk);
            #2 w++;
        end
        chk(w, (c > 3'h1) ? c - 3'h1 : 3'h0);
    endtask : fl

    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            close_out();
        end
    end

    initial begin
        int k;
        repeat (10) @(posedge clk);
        #1 rst = 1'h0;
        chk({flow_busy, flow_cost, ret_pred, redirect, ras_count}, 64'h0);
        iss(ir(PIPE_ALU, 4'h3, 4'h0, 4'hF, 4'h1, 4'h3, 4'h0, 4'h0, 1'h0),
            ir(PIPE_DATA, 4'hE, 4'h0, 4'h3, 4'h1, 4'h1, 4'h0, 4'h0, 1'h0), 2);
        iss(ir(PIPE_MUL, 4'h4, 4'h5, 4'hF, 4'h1, 4'h2, 4'h4, 4'h0, 1'h0),
            ir(PIPE_ALU, 4'hE, 4'h0, 4'h4, 4'h1, 4'h1, 4'h0, 4'h0, 1'h0), 1);
        iss(ir(PIPE_MUL, 4'h4, 4'h5, 4'hF, 4'h1, 4'h2, 4'h4, 4'h0, 1'h0),
            ir(PIPE_ALU, 4'hE, 4'h0, 4'h5, 4'h1, 4'h1, 4'h0, 4'h0, 1'h0), 3);
        iss(ir(PIPE_ALU, 4'h3, 4'h0, 4'hF, 4'h3, 4'h1, 4'h0, 4'h0, 1'h0),
            ir(PIPE_ALU, 4'hE, 4'h0, 4'hF, 4'h1, 4'h1, 4'h0, 4'h0, 1'h0), 2);
        iss(ir(PIPE_ALU, 4'h3, 4'h0, 4'hF, 4'h3, 4'h1, 4'h0, 4'h0, 1'h0),
            ir(PIPE_MUL, 4'hE, 4'h0, 4'hF, 4'h1, 4'h1, 4'h0, 4'h0, 1'h0), 0);
        iss(ir(PIPE_ALU, 4'h3, 4'h0, 4'hF, 4'h1, 4'h1, 4'h0, 4'h1, 1'h0),
            ir(PIPE_DATA, 4'hE, 4'h0, 4'hF, 4'h1, 4'h1, 4'h0, 4'h0, 1'h1), 0);
        iss(ir(PIPE_ALU, 4'h3, 4'h0, 4'hF, 4'h1, 4'h1, 4'h0, 4'h3, 1'h0),
            ir(PIPE_DATA, 4'hE, 4'h0, 4'hF, 4'h1, 4'h1, 4'h0, 4'h0, 1'h1), 2);
        foreach (rows[i]) begin
            fl(rows[i].k, rows[i].b, 32'h100 + i, rows[i].c, rows[i].n);
        end
        fl(FLOW_RET_COND, 3'h5, 32'h0, 3'h4, 3'h0);
        for (int i = 0; i < 5; i++) begin
            fl(FLOW_REL_CALL, 3'h4, 32'h200 + i, 3'h1, 3'((i < 4) ? i + 1 : 4));
        end
        for (int i = 4; i > 0; i--) begin
            fl(FLOW_RET_ALWAYS, 3'h0, 32'h0, 3'h2, 3'(i - 1));
            chk({ret_pred, ret_target}, {1'h1, 32'h200 + i});
        end
        fl(FLOW_RET_ALWAYS, 3'h4, 32'h0, 3'h4, 3'h0);
        chk(ret_pred, 1'h0);
        fl(FLOW_MOV_LINK, 3'h4, 32'h0, 3'h4, 3'h0);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            #1 go = 1'h1;
            go_val = 32'hA0 + i;
            go_dly = (i == 0) ? 4'h3 : 4'h1;
            @(posedge clk);
            #1 go = 1'h0;
            k = 0;
            while (wb_wr !== 1'h1 && k < 10) begin
                @(posedge clk);
                #1 k++;
            end
            @(posedge clk);
            #1 chk({redirect, redir_addr}, {1'h1, 32'hA0 + i});
        end
        fl(FLOW_REL_CALL, 3'h4, 32'h300, 3'h1, 3'h1);
        @(posedge clk);
        #1 flow_req = '{1'h1, FLOW_DISP_BRANCH, 1'h0, 1'h0, 1'h0, 32'h0, 32'h0};
        @(posedge clk);
        #1 flow_req.valid = 1'h0;
        rst = 1'h1;
        @(posedge clk);
        #1 rst = 1'h0;
        chk({flow_busy, flow_cost, ret_pred, redirect, ras_count}, 64'h0);
        close_out();
    end
endmodule : branch_predict_return_stack_timing_tb
